// file: hw/flash_seq_pkg.sv
/*
   Shared constants, carrier and state types of the flash program and
   erase sequencer. Assumes a 10 MHz mclk and one bus cycle per BUS_DIV
   mclk cycles.
*/
package flash_seq_pkg;
   // ==========================================================
   // Clock and bus-cycle rate
   // ==========================================================
   localparam int MCLK_MHZ = 10;
   localparam int BUS_DIV = 2;
   // ==========================================================
   // Register offsets (byte addresses) and fields
   // ==========================================================
   localparam logic [9:0] OFF_CTRL = 10'h000;
   localparam logic [9:0] OFF_SPEED = 10'h004;
   localparam logic [9:0] OFF_FIRST = 10'h008;
   localparam logic [9:0] OFF_LAST = 10'h00C;
   localparam logic [9:0] OFF_STATUS = 10'h010;
   localparam logic [9:0] OFF_BUF = 10'h100;
   localparam int CTRL_PROG_BIT = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_WDOG_DIS_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ERROR_BIT = 1;
   localparam int STAT_MASK_BIT = 2;
   localparam logic [7:0] RST_SPEED = 8'h00;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   // ==========================================================
   // Array geometry
   // ==========================================================
   localparam int BUF_DEPTH = 64;
   localparam int BUF_BITS = 6;
   localparam int ROW_BITS = 5;
   localparam int PAGE_BITS = 6;
   localparam logic [15:0] FLASH_BASE = 16'h8000;
   localparam logic [15:0] BLOCK_PROTECT_ADDR = 16'hFF00;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam logic [7:0] SPEED_MIN = 8'h04;
   localparam logic [7:0] SPEED_MAX = 8'h20;
   localparam int PROG_TIME_MIN_US = 30;
   localparam int PROG_TIME_MAX_US = 40;
   localparam logic [15:0] PROG_SLOW_CYCLES = 16'h0026;
   localparam logic [15:0] PROG_MUL = 16'h0008;
   localparam logic [15:0] PROG_ADD = 16'h0005;
   localparam int HV_LIMIT_US = 125;
   localparam int HV_GUARD_NS = 1000;
   localparam int HV_GUARD_CYCLES = (HV_GUARD_NS * MCLK_MHZ + 999) / 1000;
   localparam int ERASE_TIME_US = 4500;
   // Bus cycles per speed-code step: the code is four times fop in MHz.
   localparam int ERASE_CYCLES_PER_CODE = ERASE_TIME_US / 4;
   localparam logic [15:0] WDOG_PROG_FIRST = 16'h002A;
   localparam logic [15:0] WDOG_ERASE_BASE = 16'h0033;
   localparam logic [15:0] WDOG_ERASE_MUL = 16'h0003;
   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic latch;
      logic rowMode;
      logic hvEnable;
      logic progPulse;
      logic erasePulse;
      logic massErase;
   } flash_cmd_t;
   typedef enum logic [2:0] {IDLE, LOAD, HV_ON, PULSE, HV_OFF, DONE} state_t;
endpackage

// file: hw/cycle_timer.sv
/*
   One-shot down counter of enable ticks that fires a one-cycle pulse.
   Assumes the tick is a one-cycle enable on the same clock.
*/
module cycle_timer #(parameter int WIDTH = 16)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] loadValue,
   input wire logic tick,
   input wire logic stop,
   output logic fire
);
   // ==========================================================
   // Counter
   // ==========================================================
   logic [WIDTH-1:0] count_q;
   logic running_q;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         count_q <= '0;
         running_q <= 1'b0;
         fire <= 1'b0;
      end
      else
      begin
         fire <= 1'b0;
         if (load)
         begin
            count_q <= loadValue;
            running_q <= 1'b1;
         end
         else if (stop)
         begin
            running_q <= 1'b0;
         end
         else if (running_q && tick)
         begin
            if (count_q <= 1)
            begin
               running_q <= 1'b0;
               fire <= 1'b1;
            end
            else
            begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end
endmodule // cycle_timer

// file: hw/flash_program_erase_sequencer.sv
/*
   Flash program and erase sequencer with a classic Wishbone slave,
   a 64-byte staging buffer and a latch/pulse command port to the array.
   Assumes the array latches a byte on latch and programs the latched
   bytes while progPulse is high; protection inputs come from mclk logic.
*/
// Functional notes
// - Requests are valid only for fop 1.0 to 8.0 MHz codes.
// - Each byte program pulse lasts between 30 and 40 microseconds.
// - Pulse is 38 cycles at code 4, else eight times code plus five.
// - Watchdog enabled means every byte is programmed alone, no limits; the code refuses ranges over 64 bytes.
// - Watchdog disabled and one row means a single row pass.
// - Spanning rows: bytes singly until last row, then row; no xxFF cross.
// - High voltage stays on under 125 microseconds per single byte.
// - Interrupt mask is set while programming and restored afterwards.
// - Enabled watchdog is serviced, first 42 bus cycles after start.
// - Index pair ends at the address after the last programmed byte.
// - Block-protect address erases the whole array, else one 64-byte page.
// - Any other valid flash address erases its own page.
// - Erase pulses last 4 to 5.5 ms, scaled by the speed code.
// - Interrupt mask is set while erasing and restored afterwards.
// - Erase services watchdog first at 51 plus three times code cycles.
// - Protected erase fails unless the test voltage bypass is present.
module flash_program_erase_sequencer
#(
   parameter int ERASE_PER_CODE = flash_seq_pkg::ERASE_CYCLES_PER_CODE
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatWr,
   output logic [31:0] wbDatRd,
   output logic wbAck,
   input wire logic cpuIntMask,
   input wire logic protectEnable,
   input wire logic [15:0] protectStart,
   input wire logic hvBypassPin,
   output flash_seq_pkg::flash_cmd_t flashCmd_q,
   output logic busy_q,
   output logic watchdogKick_q,
   output logic intMaskWrite_q,
   output logic intMaskValue_q
);
   // ==========================================================
   // Declarations
   // ==========================================================
   flash_seq_pkg::state_t state_q;
   logic [7:0] speedCode_q;
   logic [15:0] indexPair_q;
   logic [15:0] lastAddr_q;
   logic [15:0] firstSaved_q;
   logic watchdogDisable_q;
   logic error_q;
   logic isErase_q;
   logic lastUnit_q;
   logic maskSaved_q;
   logic hvSync1_q;
   logic hvSync2_q;
   logic [7:0] stage [flash_seq_pkg::BUF_DEPTH];
   logic [3:0] guard_q;
   logic [1:0] div_q;
   logic busTick;
   logic wbReq;
   logic wbWrite;
   logic progGo;
   logic eraseGo;
   logic speedOk;
   logic progOk;
   logic eraseOk;
   logic isMass;
   logic eraseBlocked;
   logic [15:0] rangeLen;
   logic [15:0] progCycles;
   logic [15:0] eraseCycles;
   logic [15:0] wdogFirst;
   logic [15:0] lastRowStart;
   logic [15:0] bufOffset;
   logic rowPass;
   logic finalByte;
   logic pulseLoad;
   logic pulseFire;
   logic wdogLoad;
   logic wdogFire;
   logic wdogStop;
   logic [31:0] rdData;

   // ==========================================================
   // Bus-cycle enable and pin synchroniser
   // ==========================================================
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         div_q <= '0;
      end
      else if (div_q == 2'(flash_seq_pkg::BUS_DIV - 1))
      begin
         div_q <= '0;
      end
      else
      begin
         div_q <= div_q + 1'b1;
      end
   end
   assign busTick = (div_q == 2'(flash_seq_pkg::BUS_DIV - 1));

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         hvSync1_q <= 1'b0;
         hvSync2_q <= 1'b0;
      end
      else
      begin
         hvSync1_q <= hvBypassPin;
         hvSync2_q <= hvSync1_q;
      end
   end

   // ==========================================================
   // Request checks and derived counts
   // ==========================================================
   assign wbReq = wbCyc && wbStb && !wbAck;
   assign wbWrite = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
   assign progGo = wbWrite && (wbAdr == flash_seq_pkg::OFF_CTRL) &&
      wbDatWr[flash_seq_pkg::CTRL_PROG_BIT] && (state_q == flash_seq_pkg::IDLE);
   assign eraseGo = wbWrite && (wbAdr == flash_seq_pkg::OFF_CTRL) &&
      wbDatWr[flash_seq_pkg::CTRL_ERASE_BIT] && !progGo &&
      (state_q == flash_seq_pkg::IDLE);
   assign speedOk = (speedCode_q >= flash_seq_pkg::SPEED_MIN) &&
      (speedCode_q <= flash_seq_pkg::SPEED_MAX);
   assign rangeLen = lastAddr_q - indexPair_q;
   // A range longer than the staging buffer is refused rather than wrapped.
   assign progOk = speedOk && (lastAddr_q >= indexPair_q) &&
      (rangeLen < 16'(flash_seq_pkg::BUF_DEPTH)) &&
      (indexPair_q >= flash_seq_pkg::FLASH_BASE);
   assign isMass = (indexPair_q == flash_seq_pkg::BLOCK_PROTECT_ADDR);
   assign eraseOk = speedOk &&
      (isMass || (indexPair_q >= flash_seq_pkg::FLASH_BASE));
   assign eraseBlocked = protectEnable && !hvSync2_q &&
      (isMass || ({indexPair_q[15:flash_seq_pkg::PAGE_BITS],
      6'h00} >= protectStart));
   assign progCycles = (speedCode_q == flash_seq_pkg::SPEED_MIN) ?
      flash_seq_pkg::PROG_SLOW_CYCLES :
      16'(16'(speedCode_q) * flash_seq_pkg::PROG_MUL +
      flash_seq_pkg::PROG_ADD);
   assign eraseCycles = 16'(32'(speedCode_q) * 32'(ERASE_PER_CODE));
   assign wdogFirst = isErase_q ?
      16'(flash_seq_pkg::WDOG_ERASE_BASE +
      flash_seq_pkg::WDOG_ERASE_MUL * 16'(speedCode_q)) :
      flash_seq_pkg::WDOG_PROG_FIRST;
   // Row method needs the watchdog off; the caller keeps ranges off $xxFF.
   assign lastRowStart = {lastAddr_q[15:flash_seq_pkg::ROW_BITS], 5'h00};
   assign rowPass = watchdogDisable_q &&
      (indexPair_q >= lastRowStart);
   assign finalByte = (indexPair_q == lastAddr_q);
   assign bufOffset = indexPair_q - firstSaved_q;

   // ==========================================================
   // Register file
   // ==========================================================
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         speedCode_q <= flash_seq_pkg::RST_SPEED;
         lastAddr_q <= flash_seq_pkg::RST_ADDR;
         watchdogDisable_q <= 1'b0;
      end
      else if (wbWrite && (state_q == flash_seq_pkg::IDLE))
      begin
         case (wbAdr)
            flash_seq_pkg::OFF_CTRL:
               watchdogDisable_q <= wbDatWr[flash_seq_pkg::CTRL_WDOG_DIS_BIT];
            flash_seq_pkg::OFF_SPEED:
               speedCode_q <= wbDatWr[7:0];
            flash_seq_pkg::OFF_LAST:
            begin
               lastAddr_q[7:0] <= wbDatWr[7:0];
               if (wbSel[1])
               begin
                  lastAddr_q[15:8] <= wbDatWr[15:8];
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (wbWrite && (state_q == flash_seq_pkg::IDLE) &&
         (wbAdr[9:8] == flash_seq_pkg::OFF_BUF[9:8]))
      begin
         stage[wbAdr[7:2]] <= wbDatWr[7:0];
      end
   end

   always_comb
   begin
      rdData = 32'h0000_0000;
      case (wbAdr)
         flash_seq_pkg::OFF_CTRL:
            rdData[flash_seq_pkg::CTRL_WDOG_DIS_BIT] = watchdogDisable_q;
         flash_seq_pkg::OFF_SPEED:
            rdData[7:0] = speedCode_q;
         flash_seq_pkg::OFF_FIRST:
            rdData[15:0] = indexPair_q;
         flash_seq_pkg::OFF_LAST:
            rdData[15:0] = lastAddr_q;
         flash_seq_pkg::OFF_STATUS:
         begin
            rdData[flash_seq_pkg::STAT_BUSY_BIT] = busy_q;
            rdData[flash_seq_pkg::STAT_ERROR_BIT] = error_q;
            rdData[flash_seq_pkg::STAT_MASK_BIT] = intMaskValue_q;
         end
         default:
         begin
            if (wbAdr[9:8] == flash_seq_pkg::OFF_BUF[9:8])
            begin
               rdData[7:0] = stage[wbAdr[7:2]];
            end
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         wbAck <= 1'b0;
         wbDatRd <= 32'h0000_0000;
      end
      else
      begin
         wbAck <= wbReq;
         wbDatRd <= wbReq ? rdData : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Timers
   // ==========================================================
   assign pulseLoad = (state_q == flash_seq_pkg::HV_ON) &&
      (guard_q == 4'(flash_seq_pkg::HV_GUARD_CYCLES));
   assign wdogLoad = (state_q == flash_seq_pkg::IDLE) ?
      (progGo || eraseGo) : wdogFire;
   assign wdogStop = (state_q == flash_seq_pkg::DONE);

   cycle_timer #(.WIDTH(16)) pulseTimer
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(pulseLoad),
      .loadValue(isErase_q ? eraseCycles : progCycles),
      .tick(busTick),
      .stop(1'b0),
      .fire(pulseFire)
   );

   // The period after the first service repeats the first delay.
   cycle_timer #(.WIDTH(16)) wdogTimer
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(wdogLoad),
      .loadValue((state_q == flash_seq_pkg::IDLE) ?
         (eraseGo ? 16'(flash_seq_pkg::WDOG_ERASE_BASE +
         flash_seq_pkg::WDOG_ERASE_MUL * 16'(speedCode_q)) :
         flash_seq_pkg::WDOG_PROG_FIRST) : wdogFirst),
      .tick(busTick),
      .stop(wdogStop),
      .fire(wdogFire)
   );

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         watchdogKick_q <= 1'b0;
      end
      else
      begin
         watchdogKick_q <= wdogFire && busy_q &&
            (isErase_q || !watchdogDisable_q);
      end
   end

   // ==========================================================
   // Interrupt mask hand-over
   // ==========================================================
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         maskSaved_q <= 1'b0;
         intMaskWrite_q <= 1'b0;
         intMaskValue_q <= 1'b0;
      end
      else
      begin
         intMaskWrite_q <= 1'b0;
         if ((progGo && progOk) || (eraseGo && eraseOk && !eraseBlocked))
         begin
            maskSaved_q <= cpuIntMask;
            intMaskWrite_q <= 1'b1;
            intMaskValue_q <= 1'b1;
         end
         else if (state_q == flash_seq_pkg::DONE)
         begin
            intMaskWrite_q <= 1'b1;
            intMaskValue_q <= maskSaved_q;
         end
      end
   end

   // ==========================================================
   // Sequencer and array command port
   // ==========================================================
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q <= flash_seq_pkg::IDLE;
         indexPair_q <= flash_seq_pkg::RST_ADDR;
         firstSaved_q <= flash_seq_pkg::RST_ADDR;
         isErase_q <= 1'b0;
         lastUnit_q <= 1'b0;
         error_q <= 1'b0;
         busy_q <= 1'b0;
         guard_q <= '0;
         flashCmd_q <= '0;
      end
      else
      begin
         flashCmd_q.latch <= 1'b0;
         case (state_q)
            flash_seq_pkg::IDLE:
            begin
               if (wbWrite && (wbAdr == flash_seq_pkg::OFF_FIRST))
               begin
                  indexPair_q[7:0] <= wbDatWr[7:0];
                  if (wbSel[1])
                  begin
                     indexPair_q[15:8] <= wbDatWr[15:8];
                  end
               end
               if (progGo)
               begin
                  error_q <= !progOk;
                  if (progOk)
                  begin
                     firstSaved_q <= indexPair_q;
                     isErase_q <= 1'b0;
                     busy_q <= 1'b1;
                     state_q <= flash_seq_pkg::LOAD;
                  end
               end
               else if (eraseGo)
               begin
                  error_q <= !eraseOk || eraseBlocked;
                  if (eraseOk && !eraseBlocked)
                  begin
                     isErase_q <= 1'b1;
                     busy_q <= 1'b1;
                     guard_q <= '0;
                     flashCmd_q.addr <= {indexPair_q[15:6], 6'h00};
                     flashCmd_q.massErase <= isMass;
                     flashCmd_q.hvEnable <= 1'b1;
                     state_q <= flash_seq_pkg::HV_ON;
                  end
               end
            end
            flash_seq_pkg::LOAD:
            begin
               flashCmd_q.addr <= indexPair_q;
               flashCmd_q.data <= stage[bufOffset[5:0]];
               flashCmd_q.latch <= 1'b1;
               flashCmd_q.rowMode <= rowPass;
               indexPair_q <= indexPair_q + 1'b1;
               if (!rowPass || finalByte)
               begin
                  lastUnit_q <= finalByte;
                  guard_q <= '0;
                  flashCmd_q.hvEnable <= 1'b1;
                  state_q <= flash_seq_pkg::HV_ON;
               end
            end
            flash_seq_pkg::HV_ON:
            begin
               guard_q <= guard_q + 1'b1;
               if (pulseLoad)
               begin
                  flashCmd_q.progPulse <= !isErase_q;
                  flashCmd_q.erasePulse <= isErase_q;
                  state_q <= flash_seq_pkg::PULSE;
               end
            end
            flash_seq_pkg::PULSE:
            begin
               if (pulseFire)
               begin
                  flashCmd_q.progPulse <= 1'b0;
                  flashCmd_q.erasePulse <= 1'b0;
                  guard_q <= '0;
                  state_q <= flash_seq_pkg::HV_OFF;
               end
            end
            flash_seq_pkg::HV_OFF:
            begin
               guard_q <= guard_q + 1'b1;
               // Short guards keep high voltage well under its limit.
               if (guard_q == 4'(flash_seq_pkg::HV_GUARD_CYCLES))
               begin
                  flashCmd_q.hvEnable <= 1'b0;
                  flashCmd_q.rowMode <= 1'b0;
                  flashCmd_q.massErase <= 1'b0;
                  state_q <= (isErase_q || lastUnit_q) ?
                     flash_seq_pkg::DONE : flash_seq_pkg::LOAD;
               end
            end
            flash_seq_pkg::DONE:
            begin
               busy_q <= 1'b0;
               state_q <= flash_seq_pkg::IDLE;
            end
            default:
            begin
               state_q <= flash_seq_pkg::IDLE;
            end
         endcase
      end
   end
endmodule // flash_program_erase_sequencer

// file: sim/flash_seq_asserts.sv
/* Port checker of the flash sequencer.
   Bound to every sequencer instance; sees its ports only. */
// ==========
// Port timing checks
module flash_seq_asserts (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic [31:0] wbDatRd,
   input wire logic wbAck,
   input wire flash_seq_pkg::flash_cmd_t flashCmd_q,
   input wire logic busy_q,
   input wire logic watchdogKick_q,
   input wire logic intMaskWrite_q,
   input wire logic intMaskValue_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // Erase keeps high voltage for milliseconds, so it is exempt.
   logic [11:0] hvCnt_q;
   logic erasing_q;
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !flashCmd_q.hvEnable)
         hvCnt_q <= 12'h0;
      else if (hvCnt_q != 12'hFFF)
         hvCnt_q <= hvCnt_q + 12'h1;
   end
   always_ff @(posedge mclk)
   begin
      if (!reset_n || !busy_q)
         erasing_q <= 1'b0;
      else if (flashCmd_q.erasePulse)
         erasing_q <= 1'b1;
   end
   ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   rd_idle_a: assert property (!wbAck |-> wbDatRd == 32'h0)
      else $error("read data not zero outside ack");
   mask_set_a: assert property ($rose(busy_q) |-> ##[0:2]
      (intMaskWrite_q && intMaskValue_q))
      else $error("mask not set at start");
   mask_end_a: assert property ($fell(busy_q) |-> intMaskWrite_q
      || $past(intMaskWrite_q) || $past(intMaskWrite_q, 2))
      else $error("mask not restored at end");
   pulse_busy_a: assert property (flashCmd_q.progPulse
      || flashCmd_q.erasePulse |-> busy_q)
      else $error("pulse outside busy");
   hv_guard_a: assert property ($rose(flashCmd_q.progPulse)
      |-> $past(flashCmd_q.hvEnable, 8))
      else $error("pulse without settled high voltage");
   hv_limit_a: assert property (hvCnt_q < 12'h4E2 || erasing_q)
      else $error("high voltage on too long");
   kick_pulse_a: assert property (watchdogKick_q |=> !watchdogKick_q)
      else $error("watchdog kick longer than one cycle");
   kick_busy_a: assert property (watchdogKick_q
      |-> busy_q || $past(busy_q))
      else $error("watchdog kick while idle");
endmodule // flash_seq_asserts
bind flash_program_erase_sequencer flash_seq_asserts chk_i (.mclk, .reset_n,
   .wbCyc, .wbStb, .wbDatRd, .wbAck, .flashCmd_q, .busy_q, .watchdogKick_q,
   .intMaskWrite_q, .intMaskValue_q);

// file: sim/flash_array_model.sv
/* Behavioural flash array on the sequencer's command port.
   Assumes registered commands on mclk; clr restarts its counts. */
// ==========
// Array model
module flash_array_model (
   input wire logic mclk,
   input wire logic clr,
   input wire flash_seq_pkg::flash_cmd_t cmd,
   output logic [7:0] nPulse,
   output logic [15:0] pLen,
   output logic [15:0] eLen,
   output logic [15:0] eAddr,
   output logic eMass
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic prev;
   always @(posedge mclk)
   begin
      prev <= cmd.progPulse;
      if (cmd.latch)
         mem[cmd.addr[7:0]] <= cmd.data;
      if (cmd.erasePulse)
      begin
         eAddr <= cmd.addr;
         eMass <= cmd.massErase;
      end
      if (clr)
      begin
         nPulse <= 8'h0;
         pLen <= 16'h0;
         eLen <= 16'h0;
      end
      else
      begin
         nPulse <= nPulse + 8'(cmd.progPulse && !prev);
         pLen <= pLen + 16'(cmd.progPulse);
         eLen <= eLen + 16'(cmd.erasePulse);
      end
   end
endmodule // flash_array_model

// file: sim/testbench.sv
/* Self-checking bench of the flash sequencer.
   Drives Wishbone at mclk edges; an array model watches the commands. */
// ==========
// Bench
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, reset_n, wbCyc, wbStb, wbWe, cpuIntMask, clr, eMass;
   logic protectEnable, hvBypassPin, wbAck, busy_q, kick, mWr, mVal;
   logic [9:0] wbAdr;
   logic [31:0] wbDatWr, wbDatRd, q;
   logic [15:0] protectStart, since, firstKick, pLen, eLen, eAddr;
   logic [7:0] nKick, nPulse;
   logic [7:0] bad [2] = '{8'h03, 8'h21};
   flash_seq_pkg::flash_cmd_t cmd;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   flash_program_erase_sequencer #(.ERASE_PER_CODE(40)) DUT (.mclk,
      .reset_n, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(4'hF), .wbDatWr,
      .wbDatRd, .wbAck, .cpuIntMask, .protectEnable, .protectStart,
      .hvBypassPin, .flashCmd_q(cmd), .busy_q, .watchdogKick_q(kick),
      .intMaskWrite_q(mWr), .intMaskValue_q(mVal));
   flash_array_model flash (.mclk, .clr, .cmd, .nPulse, .pLen, .eLen,
      .eAddr, .eMass);
   task automatic end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // The request stands until ack is sampled, then drops for a cycle.
   task automatic xfer(input logic w, input logic [9:0] a,
      input logic [31:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatWr <= d;
      @(posedge mclk);
      while (wbAck !== 1'b1)
         @(posedge mclk);
      q = wbDatRd;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic start(input logic [2:0] c, input logic [7:0] s,
      input logic [15:0] f, input logic [15:0] l);
      clr <= 1'b1;
      xfer(1'b1, flash_seq_pkg::OFF_SPEED, {24'h0, s});
      xfer(1'b1, flash_seq_pkg::OFF_FIRST, {16'h0, f});
      xfer(1'b1, flash_seq_pkg::OFF_LAST, {16'h0, l});
      for (int i = 0; i <= int'(l - f) && i < 64; i++)
         xfer(1'b1, flash_seq_pkg::OFF_BUF + 10'(4 * i), 32'hA0 + 32'(i));
      clr <= 1'b0;
      xfer(1'b1, flash_seq_pkg::OFF_CTRL, {29'h0, c});
   endtask
   task automatic idle;
      while (busy_q !== 1'b0)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask
   // Kick delay is measured from the rise of busy.
   always @(posedge mclk)
   begin
      since <= busy_q ? since + 16'h1 : 16'h0;
      nKick <= clr ? 8'h0 : nKick + 8'(kick === 1'b1);
      if (kick === 1'b1 && nKick == 8'h0)
         firstKick <= since;
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial
   begin
      {reset_n, wbCyc, wbStb, wbWe, cpuIntMask, clr} = 6'h0;
      {protectEnable, hvBypassPin, wbAdr, wbDatWr} = 44'h0;
      {protectStart, since, firstKick, nKick} = 56'h0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      rd(flash_seq_pkg::OFF_SPEED, 32'h0);
      rd(flash_seq_pkg::OFF_FIRST, 32'h0);
      rd(flash_seq_pkg::OFF_STATUS, 32'h0);
      rd(10'h3FC, 32'h0);
      foreach (bad[i])
      begin
         start(3'h1, bad[i], 16'h8000, 16'h8000);
         rd(flash_seq_pkg::OFF_STATUS, 32'h2);
      end
      $display("test reset and speed done");
      cpuIntMask <= 1'b1;
      start(3'h1, 8'h05, 16'h801E, 16'h8020);
      rd(flash_seq_pkg::OFF_STATUS, 32'h5);
      xfer(1'b1, flash_seq_pkg::OFF_FIRST, 32'h9000);
      idle();
      chk(nPulse, 32'h3);
      chk(pLen >= 16'd270 && pLen <= 16'd276, 32'h1);
      for (int i = 0; i < 3; i++)
         chk(flash.mem[8'h1E + 8'(i)], 32'hA0 + 32'(i));
      rd(flash_seq_pkg::OFF_FIRST, 32'h8021);
      rd(flash_seq_pkg::OFF_STATUS, 32'h4);
      chk(firstKick >= 16'd82 && firstKick <= 16'd90, 32'h1);
      $display("test byte program done");
      cpuIntMask <= 1'b0;
      start(3'h5, 8'h04, 16'h801E, 16'h8021);
      idle();
      chk(nPulse, 32'h3);
      chk(pLen >= 16'd228 && pLen <= 16'd234, 32'h1);
      chk(nKick, 32'h0);
      rd(flash_seq_pkg::OFF_FIRST, 32'h8022);
      rd(flash_seq_pkg::OFF_STATUS, 32'h0);
      start(3'h5, 8'h20, 16'h8040, 16'h805F);
      idle();
      chk(nPulse, 32'h1);
      chk(pLen >= 16'd522 && pLen <= 16'd525, 32'h1);
      chk(flash.mem[8'h5F], 32'hBF);
      $display("test row program done");
      start(3'h2, 8'h04, 16'h8045, 16'h8045);
      rd(flash_seq_pkg::OFF_STATUS, 32'h5);
      idle();
      chk({eMass, eAddr}, 32'h8040);
      chk(eLen >= 16'd320 && eLen <= 16'd323, 32'h1);
      chk(firstKick >= 16'd124 && firstKick <= 16'd132, 32'h1);
      rd(flash_seq_pkg::OFF_STATUS, 32'h0);
      start(3'h2, 8'h04, 16'hFF00, 16'hFF00);
      idle();
      chk(eMass, 32'h1);
      $display("test erase done");
      protectEnable <= 1'b1;
      protectStart <= 16'h8000;
      start(3'h2, 8'h04, 16'h8100, 16'h8100);
      rd(flash_seq_pkg::OFF_STATUS, 32'h2);
      chk(eLen, 32'h0);
      hvBypassPin <= 1'b1;
      repeat (3) @(posedge mclk);
      start(3'h2, 8'h04, 16'h8100, 16'h8100);
      idle();
      chk(eAddr, 32'h8100);
      $display("test protection done");
      end_sim();
   end
endmodule // testbench
